// >>> bench/scs_checker.sv
`timescale 1ns/1ns
module scs_checker
    import scs_pkg::*;
#(
    parameter logic [7:0] FACTORY_TRIM = 8'h00
) (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic       clkout_enable,
    input wire logic       port3_bit_three_is_out,
    input wire logic       port3_bit_two_out,
    input wire logic       port3_bit_two_oe_n_req,
    input wire logic [4:0] sig_addr,
    input wire logic [7:0] sig_data,
    input wire logic       sys_clk,
    input wire logic       cpu_clk,
    input wire logic       amp_enable,
    input wire logic       osc_in_pin_o,
    input wire logic       osc_in_pin_oe_n,
    input wire logic       osc_out_pin_oe_n,
    input wire logic       port3_bit_two,
    input wire logic       port3_bit_three,
    input wire scs_src_t   src_sel,
    input wire logic       rsvd_sel
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // two edges past the latch point
    sequence s_run; $past(rstn, 2) && rstn; endsequence
    sequence s_cko; clkout_enable && port3_bit_three_is_out; endsequence
    property p_cpu; cpu_clk == sys_clk; endproperty
    property p_rsvd; rsvd_sel == (src_sel == SCS_RSVD); endproperty
    property p_amp; $past(rstn) |-> amp_enable == (src_sel == SCS_XTAL);
    endproperty
    property p_hold; s_run |-> $stable(src_sel); endproperty
    property p_xtal; src_sel == SCS_XTAL |=> osc_in_pin_oe_n
        && osc_out_pin_oe_n && !port3_bit_two && !port3_bit_three; endproperty
    property p_rc; src_sel == SCS_RC |=> osc_in_pin_oe_n ==
        $past(port3_bit_two_oe_n_req) && osc_in_pin_o == $past(port3_bit_two_out);
    endproperty
    property p_cko; src_sel inside {SCS_RC, SCS_EXT} ##0 s_cko
        |=> !osc_out_pin_oe_n; endproperty
    property p_sig; sig_data == (($past(sig_addr) == 5'h07) ? FACTORY_TRIM
        : 8'h00); endproperty
    // one label per relation
    a_cpu: assert property (p_cpu) else $error("cpu clock differs");
    a_rsvd: assert property (p_rsvd) else $error("reserved flag");
    a_amp: assert property (p_amp) else $error("amplifier enable");
    a_hold: assert property (p_hold) else $error("source changed");
    a_xtal: assert property (p_xtal) else $error("crystal pins");
    a_rc: assert property (p_rc) else $error("rc pin drive");
    a_cko: assert property (p_cko) else $error("clock out off");
    a_sig: assert property (p_sig) else $error("signature data");
endmodule
bind scs_top scs_checker #(.FACTORY_TRIM(FACTORY_TRIM)) u_chk (.mclk, .rstn,
    .clkout_enable, .port3_bit_three_is_out, .port3_bit_two_out,
    .port3_bit_two_oe_n_req, .sig_addr, .sig_data, .sys_clk, .cpu_clk,
    .amp_enable, .osc_in_pin_o, .osc_in_pin_oe_n, .osc_out_pin_oe_n,
    .port3_bit_two, .port3_bit_three, .src_sel, .rsvd_sel);

// >>> bench/scs_clk_drv.sv
`timescale 1ns/1ns
module scs_clk_drv #(
    parameter int HALF = 5
) (
    input  wire logic mclk,
    input  wire logic run,
    output logic      clk
);
    int cnt = 0;
    initial clk = 1'b0;
    // crystal or driver clock, still while not running
    always @(posedge mclk) begin
        if (run) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) clk <= ~clk;
        end
    end
endmodule

// >>> bench/scs_top_bench.sv
`timescale 1ns/1ns
module scs_top_bench
    import scs_pkg::*;
;
    localparam logic [7:0] TRIM = 8'h5A; // arbitrary factory value
    logic mclk = 0, rstn = 0, xtal_clk, use_ext = 0, pin_lvl = 0, osc_in_pin;
    logic pin3_lvl = 0, osc_out_pin;
    logic [1:0] clk_src_fuse = 0, clkout_divide_sel = 0;
    logic [7:0] rc_trim_fuse = 0, sig_data;
    logic [4:0] sig_addr = 0;
    logic clkout_enable = 0, port3_bit_three_is_out = 0;
    logic port3_bit_two_out = 0, port3_bit_three_out = 0;
    logic port3_bit_two_oe_n_req = 1, port3_bit_three_oe_n_req = 1;
    logic sys_clk, cpu_clk, amp_enable, osc_in_pin_o, osc_in_pin_oe_n;
    logic osc_out_pin_o, osc_out_pin_oe_n, port3_bit_two, port3_bit_three;
    logic rsvd_sel;
    scs_src_t src_sel;
    int bad_count = 0, comparisons = 0, cyc = 0, c, e;
    always #2 mclk = ~mclk;
    assign osc_in_pin = use_ext ? xtal_clk : pin_lvl;
    // released pin shows the board level, driven pin its own output
    assign osc_out_pin = osc_out_pin_oe_n ? pin3_lvl : osc_out_pin_o;
    // crystal swings only with the amplifier on; driver runs in ext mode
    scs_clk_drv u_drv (.mclk, .run(amp_enable || use_ext), .clk(xtal_clk));
    scs_top #(.FACTORY_TRIM(TRIM)) u_dut (.mclk, .rstn, .clk_src_fuse,
        .rc_trim_fuse, .osc_in_pin, .osc_out_pin, .xtal_clk, .clkout_enable,
        .clkout_divide_sel, .port3_bit_three_is_out, .port3_bit_two_out,
        .port3_bit_three_out, .port3_bit_two_oe_n_req,
        .port3_bit_three_oe_n_req, .sig_addr, .sig_data, .sys_clk, .cpu_clk,
        .amp_enable, .osc_in_pin_o, .osc_in_pin_oe_n, .osc_out_pin_o,
        .osc_out_pin_oe_n, .port3_bit_two, .port3_bit_three, .src_sel,
        .rsvd_sel);
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // reset with given fuses, then move the source fuse away
    task automatic boot(input logic [1:0] f, input logic [7:0] t);
        @(posedge mclk);
        rstn <= 0;
        clk_src_fuse <= f;
        rc_trim_fuse <= t;
        sig_addr <= 0;
        use_ext <= (f == 2'h2);
        repeat (16) @(posedge mclk);
        rstn <= 1;
        repeat (2) @(posedge mclk);
        clk_src_fuse <= ~f;
        repeat (3) @(negedge mclk);
    endtask
    // count level changes of sys_clk or the clock out pin
    task automatic tog(input bit w, input int n, output int k);
        logic prev;
        k = 0;
        @(negedge mclk);
        prev = w ? osc_out_pin_o : sys_clk;
        repeat (n) begin
            @(negedge mclk);
            if ((w ? osc_out_pin_o : sys_clk) !== prev) k++;
            prev = w ? osc_out_pin_o : sys_clk;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            summarize;
        end
    end
    initial begin
        for (int s = 0; s < 4; s++) begin
            boot(s[1:0], 8'h00);
            check(src_sel, s[1:0]);
            check(rsvd_sel, s == 1);
            check(amp_enable, s == 0);
            tog(0, 200, c);
            check(c != 0, s != 1);
            @(posedge mclk);
            clkout_enable <= 1;
            port3_bit_three_is_out <= 1;
            pin_lvl <= 1;
            pin3_lvl <= 1;
            for (int d = 0; d < 4; d++) begin
                @(posedge mclk);
                clkout_divide_sel <= d[1:0];
                repeat (3) @(negedge mclk);
                // 680 cycles: 68 ext clock periods or 20 rc periods
                tog(1, 680, c);
                e = ((s == 2) ? 68 : 20) >> d;
                if (s >= 2) check(c + 1 >= e && c <= e + 1, 1);
                check(osc_out_pin_oe_n, s < 2);
            end
            check(port3_bit_two, s == 3);
            @(posedge mclk);
            clkout_enable <= 0;
            repeat (6) @(negedge mclk);
            check(port3_bit_three, s >= 2);
            @(posedge mclk);
            pin_lvl <= 0;
            pin3_lvl <= 0;
        end
        boot(2'h3, 8'h10);
        tog(0, 256, c);
        check(c >= 7 && c <= 9, 1);
        @(posedge mclk);
        clkout_enable <= 1;
        port3_bit_three_is_out <= 0;
        port3_bit_two_oe_n_req <= 0;
        port3_bit_two_out <= 1;
        sig_addr <= 5'h07;
        repeat (3) @(negedge mclk);
        check(osc_out_pin_oe_n, 1);
        check({osc_in_pin_o, osc_in_pin_oe_n}, 2'b10);
        check(sig_data, TRIM);
        @(posedge mclk);
        sig_addr <= 5'h06;
        repeat (2) @(negedge mclk);
        check(sig_data, 8'h00);
        summarize;
    end
endmodule

// >>> design/scs_clkout_div.sv
`timescale 1ns/1ns
`include "scs_defines.svh"
module scs_clkout_div
    import scs_pkg::*;
#(
    parameter int CNT_W = `SCS_DIVCNT_W
) (
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire logic                  run,
    input  wire logic                  tick,
    input  wire logic [`SCS_DIV_W-1:0] div_sel,
    output logic                       clk_div
);
    logic [CNT_W-1:0] cnt;

    // counts system clock rising edges, cleared while idle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt <= `SCS_DIVCNT_RESET;
        end else if (!run) begin
            cnt <= `SCS_DIVCNT_RESET;
        end else if (tick) begin
            cnt <= cnt + 1'b1;
        end
    end

    // bit n of the edge count toggles at f/2^(n+1)
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            clk_div <= 1'b0;
        end else if (!run) begin
            clk_div <= 1'b0;
        end else if (tick) begin
            clk_div <= (next_cnt_bit(cnt, div_sel));
        end
    end

    function automatic logic next_cnt_bit(
        input logic [CNT_W-1:0]      c,
        input logic [`SCS_DIV_W-1:0] s
    );
        logic [CNT_W-1:0] n;
        n = c + 1'b1;
        next_cnt_bit = n[s];
    endfunction
endmodule

// >>> design/scs_defines.svh
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH
// Contract
// - Clock source fuses: 00 crystal, 01 reserved, 10 external, 11 RC.
// - CPU clock equals selected system clock, never divided.
// - Crystal mode enables the inverting amplifier across both oscillator pins.
// - Crystal mode disables input and output of port bits two and three.
// - External mode turns amplifier off; clock taken from the input pin.
// - External mode: output pin free, general I/O, or divided clock out.
// - RC mode gives both oscillator pins to the port as bits two, three.
// - RC mode may drive divided system clock on the output pin.
// - Internal RC oscillator nominal 8.0 MHz, used when selected.
// - RC trim fuses set the RC oscillator frequency.
// - Factory RC trim copy readable at signature location 0007h.
// - Clock out divides system clock by 2, 4, 8 or 16 per code.
// - Clock out only in RC or external mode with port bit as output.

// clock source fuse codes
`define SCS_SRC_XTAL      2'h0
`define SCS_SRC_RSVD      2'h1
`define SCS_SRC_EXT       2'h2
`define SCS_SRC_RC        2'h3
// field widths and locations
`define SCS_SRC_W         2
`define SCS_DIV_W         2
`define SCS_TRIM_W        8
`define SCS_SIG_ADDR_W    5
`define SCS_SIG_TRIM_ADDR 5'h07
// nominal RC frequency in kHz
`define SCS_RC_FREQ_KHZ   8000
// divider counter width for f/16
`define SCS_DIVCNT_W      4
`define SCS_DIVCNT_RESET  4'h0
`define SCS_TRIM_RESET    8'h00
`endif

// >>> design/scs_pkg.sv
package scs_pkg;
`include "scs_defines.svh"
    // selected clock source
    typedef enum logic [1:0] {
        SCS_XTAL = `SCS_SRC_XTAL,
        SCS_RSVD = `SCS_SRC_RSVD,
        SCS_EXT  = `SCS_SRC_EXT,
        SCS_RC   = `SCS_SRC_RC
    } scs_src_t;

    // pin function controls for the two oscillator pins
    typedef struct packed {
        logic amp_en;
        logic in_pin_port;
        logic out_pin_port;
        logic out_pin_clk;
    } scs_pinctl_t;
endpackage

// >>> design/scs_rc_osc.sv
`timescale 1ns/1ns
`include "scs_defines.svh"
module scs_rc_osc
    import scs_pkg::*;
#(
    parameter int HALF_BASE = 16
) (
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    input  wire logic                   enable,
    input  wire logic [`SCS_TRIM_W-1:0] trim,
    output logic                        rc_clk
);
    // behavioural stand-in: half period grows with trim code
    logic [`SCS_TRIM_W:0] cnt;
    logic [`SCS_TRIM_W:0] half;

    assign half = (`SCS_TRIM_W+1)'(HALF_BASE) + {1'b0, trim};

    // toggle output every half period while enabled
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt    <= '0;
            rc_clk <= 1'b0;
        end else if (!enable) begin
            cnt    <= '0;
            rc_clk <= 1'b0;
        end else if (cnt >= half) begin
            cnt    <= '0;
            rc_clk <= ~rc_clk;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule

// >>> design/scs_top.sv
`timescale 1ns/1ns
`include "scs_defines.svh"
module scs_top
    import scs_pkg::*;
#(
    parameter logic [`SCS_TRIM_W-1:0] FACTORY_TRIM = `SCS_TRIM_RESET
) (
    input  wire logic                      mclk,
    input  wire logic                      rstn,
    input  wire logic [`SCS_SRC_W-1:0]     clk_src_fuse,
    input  wire logic [`SCS_TRIM_W-1:0]    rc_trim_fuse,
    input  wire logic                      osc_in_pin,
    input  wire logic                      osc_out_pin,
    input  wire logic                      xtal_clk,
    input  wire logic                      clkout_enable,
    input  wire logic [`SCS_DIV_W-1:0]     clkout_divide_sel,
    input  wire logic                      port3_bit_three_is_out,
    input  wire logic                      port3_bit_two_out,
    input  wire logic                      port3_bit_three_out,
    input  wire logic                      port3_bit_two_oe_n_req,
    input  wire logic                      port3_bit_three_oe_n_req,
    input  wire logic [`SCS_SIG_ADDR_W-1:0] sig_addr,
    output logic [`SCS_TRIM_W-1:0]         sig_data,
    output logic                           sys_clk,
    output logic                           cpu_clk,
    output logic                           amp_enable,
    output logic                           osc_in_pin_o,
    output logic                           osc_in_pin_oe_n,
    output logic                           osc_out_pin_o,
    output logic                           osc_out_pin_oe_n,
    output logic                           port3_bit_two,
    output logic                           port3_bit_three,
    output scs_src_t                       src_sel,
    output logic                           rsvd_sel
);
    ////////////////////////////////////////////////////////////////////
    logic        pin_s1;
    logic        pin_s2;
    logic        pin3_s1;
    logic        pin3_s2;
    logic        fuse_taken;
    logic        rc_clk;
    logic        clk_div;
    logic        clk_run;
    logic        sys_clk_d;
    logic        sys_tick;
    scs_pinctl_t pinctl;

    // source fuse latched on first clock after reset release
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            fuse_taken <= 1'b0;
            src_sel    <= SCS_XTAL;
        end else if (!fuse_taken) begin
            fuse_taken <= 1'b1;
            src_sel    <= scs_src_t'(clk_src_fuse);
        end
    end

    assign rsvd_sel = (src_sel == SCS_RSVD);

    // pin synchronisers for both oscillator pins
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_s1  <= 1'b0;
            pin_s2  <= 1'b0;
            pin3_s1 <= 1'b0;
            pin3_s2 <= 1'b0;
        end else begin
            pin_s1  <= osc_in_pin;
            pin_s2  <= pin_s1;
            pin3_s1 <= osc_out_pin;
            pin3_s2 <= pin3_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin function decode per source
    always_comb begin
        pinctl = '0;
        unique case (src_sel)
            SCS_XTAL: pinctl.amp_en = 1'b1;
            SCS_EXT: begin
                pinctl.out_pin_port = 1'b1;
                pinctl.out_pin_clk  = clkout_enable;
            end
            SCS_RC: begin
                pinctl.in_pin_port  = 1'b1;
                pinctl.out_pin_port = 1'b1;
                pinctl.out_pin_clk  = clkout_enable;
            end
            SCS_RSVD: pinctl = '0;
        endcase
    end

    assign amp_enable = pinctl.amp_en && fuse_taken;

    // clock out needs proper mode and port bit as output
    assign clk_run = pinctl.out_pin_clk && port3_bit_three_is_out;

    scs_rc_osc u_rc (
        .mclk   (mclk),
        .rstn   (rstn),
        .enable (src_sel == SCS_RC && fuse_taken),
        .trim   (rc_trim_fuse),
        .rc_clk (rc_clk)
    );

    scs_clkout_div u_div (
        .mclk    (mclk),
        .rstn    (rstn),
        .run     (clk_run),
        .tick    (sys_tick),
        .div_sel (clkout_divide_sel),
        .clk_div (clk_div)
    );

    ////////////////////////////////////////////////////////////////////
    // system clock mux; cpu clock is the same, undivided
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sys_clk <= 1'b0;
        end else begin
            unique case (src_sel)
                SCS_XTAL: sys_clk <= xtal_clk;
                SCS_EXT:  sys_clk <= pin_s2;
                SCS_RC:   sys_clk <= rc_clk;
                SCS_RSVD: sys_clk <= 1'b0;
            endcase
        end
    end

    // rising edges of the system clock pace the clock out divider
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sys_clk_d <= 1'b0;
        end else begin
            sys_clk_d <= sys_clk;
        end
    end

    assign sys_tick = sys_clk && !sys_clk_d;

    assign cpu_clk = sys_clk;

    // oscillator pin drivers; oe_n low means driving
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            osc_in_pin_o     <= 1'b0;
            osc_in_pin_oe_n  <= 1'b1;
            osc_out_pin_o    <= 1'b0;
            osc_out_pin_oe_n <= 1'b1;
        end else begin
            osc_in_pin_o    <= port3_bit_two_out;
            osc_in_pin_oe_n <= !(pinctl.in_pin_port
                                 && !port3_bit_two_oe_n_req);
            if (clk_run) begin
                osc_out_pin_o    <= clk_div;
                osc_out_pin_oe_n <= 1'b0;
            end else begin
                osc_out_pin_o    <= port3_bit_three_out;
                osc_out_pin_oe_n <= !(pinctl.out_pin_port
                                      && !port3_bit_three_oe_n_req);
            end
        end
    end

    // port input values; zero when the pin is not a port
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            port3_bit_two   <= 1'b0;
            port3_bit_three <= 1'b0;
        end else begin
            port3_bit_two   <= pinctl.in_pin_port && pin_s2;
            port3_bit_three <= pinctl.out_pin_port && pin3_s2;
        end
    end

    // signature read: factory trim copy at its location
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sig_data <= `SCS_TRIM_RESET;
        end else if (sig_addr == `SCS_SIG_TRIM_ADDR) begin
            sig_data <= FACTORY_TRIM;
        end else begin
            sig_data <= `SCS_TRIM_RESET;
        end
    end
endmodule
